// [inc/fifo_flag_consts.vh]
// constants for the per-channel fifo flag logic and its offset chain
// assumes inclusion by the flag logic design file of this block
`ifndef FIFO_FLAG_CONSTS_VH
`define FIFO_FLAG_CONSTS_VH

`define CHANNELS        4
`define WORD_BITS       10
`define COUNT_BITS      18
`define OFFSET_BITS     17
`define CHAIN_BITS      136
`define STAGE_DEPTH     16
`define STAGE_PTR_BITS  4

// smallest depth in words, shifted up by the size select
`define BASE_DEPTH      18'h0_8000
// offset register width for the smallest size, x10 and x20 dual
`define BASE_OFS_WIDTH  5'h0F
`define X20_OFS_WIDTH   5'h0E
`define SIZE_LARGEST    2'h2

// default offsets chosen by default_offset_select
`define DEFAULT_OFS_0   17'h0_0007
`define DEFAULT_OFS_1   17'h0_003F
`define DEFAULT_OFS_2   17'h0_007F
`define DEFAULT_OFS_3   17'h0_03FF

// register stages between raw flag and pin
`define EMPTY_STAGES    2
`define FULL_STAGES     2
`define ROOM_STAGES     2
`define READY_STAGES    3

`endif

// [verilog/stage_fifo.v]
// small synchronous fifo with registered read data
// assumes one clock and an active-low asynchronous reset
`timescale 1ns/100ps
module stage_fifo #(
    parameter WIDTH    = 10,
    parameter DEPTH    = 16,
    parameter PTR_BITS = 4
) (
    input  wire             sys_clk,
    input  wire             arst_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0]  mem [0:DEPTH-1];
    reg [PTR_BITS-1:0] wr_ptr_reg;
    reg [PTR_BITS-1:0] rd_ptr_reg;
    reg [PTR_BITS:0]   fill_reg;
    reg [WIDTH-1:0]    out_data_reg;
    reg                out_valid_reg;
    wire               push;
    wire               pop;

    assign in_ready  = (fill_reg != DEPTH[PTR_BITS:0]);
    assign push      = in_valid & in_ready;
    // memory feeds the output register whenever it is free or being drained
    assign pop       = (fill_reg != {(PTR_BITS+1){1'b0}}) & (~out_valid_reg | out_ready);
    assign out_valid = out_valid_reg;
    assign out_data  = out_data_reg;

    always @(posedge sys_clk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ptr_reg    <= {PTR_BITS{1'b0}};
            rd_ptr_reg    <= {PTR_BITS{1'b0}};
            fill_reg      <= {(PTR_BITS+1){1'b0}};
            out_data_reg  <= {WIDTH{1'b0}};
            out_valid_reg <= 1'b0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg   <= rd_ptr_reg + 1'b1;
                out_data_reg <= mem[rd_ptr_reg];
            end
            if (push & ~pop) begin
                fill_reg <= fill_reg + 1'b1;
            end else if (pop & ~push) begin
                fill_reg <= fill_reg - 1'b1;
            end
            if (pop) begin
                out_valid_reg <= 1'b1;
            end else if (out_ready) begin
                out_valid_reg <= 1'b0;
            end
        end
    end
endmodule // stage_fifo

// [verilog/fifo_status_flag_logic.v]
// four-channel fifo status flags, serial offset chain and data staging
// assumes all inputs synchronous to sys_clk; word storage sits outside,
// fed through store_* and read through fetch_*
//
// Behaviour
// (RULE1) writer holds enable and select low
// (RULE2) standard: empty flag rises on first write
// (RULE3) standard: almost-empty high at offset plus one
// (RULE4) standard: almost-full low at depth minus offset
// (RULE5) standard: full low at depth, blocks writes
// (RULE6) x20 dual halves depth for both flags
// (RULE7) read from full releases full, then almost-full
// (RULE8) almost-empty low at offset words left
// (RULE9) standard: empty low after last read, blocks reads
// (RULE10) read enable ignored when empty; select drives outputs
// (RULE11) standard: empty and full flags two stages
// (RULE12) standard mode works at either data rate
// (RULE13) fall-through: ready flag low after first write
// (RULE14) fall-through: almost-empty high at offset plus two
// (RULE15) fall-through: almost-full low at depth+1 minus offset
// (RULE16) fall-through: room flag low at depth+1, blocks
// (RULE17) fall-through x20 dual halves depth plus one
// (RULE18) fall-through: ready flag high after last read
// (RULE19) fall-through: ready three stages, room two stages
// (RULE20) quad chain order fifo 3,2,1,0, lsb first
// (RULE21) higher serial bit is register msb
// (RULE22) dual chain holds only fifos 2 and 0
// (RULE23) mode pin sampled at reset for all channels
// (RULE24) fall-through first word shows after three edges
// (RULE25) offsets default from select pins at reset
// (RULE26) write and read flags from one clock here
// (RULE27) each channel has own counter, offsets, flags
`timescale 1ns/100ps
`include "fifo_flag_consts.vh"
module fifo_status_flag_logic (
    input  wire                            sys_clk,
    input  wire                            arst_n,
    input  wire                            fall_through_mode,
    input  wire                            dual_mode,
    input  wire                            port_width_select,
    input  wire [1:0]                      device_size,
    input  wire [1:0]                      default_offset_select,
    input  wire [`CHANNELS-1:0]            write_enable_n,
    input  wire [`CHANNELS-1:0]            write_select_n,
    input  wire [`CHANNELS*`WORD_BITS-1:0] write_data,
    output wire [`CHANNELS-1:0]            store_valid,
    input  wire [`CHANNELS-1:0]            store_ready,
    output wire [`CHANNELS*`WORD_BITS-1:0] store_data,
    input  wire [`CHANNELS-1:0]            read_enable_n,
    input  wire [`CHANNELS-1:0]            read_select_n,
    output wire [`CHANNELS-1:0]            fetch_req,
    input  wire [`CHANNELS*`WORD_BITS-1:0] fetch_data,
    output wire [`CHANNELS*`WORD_BITS-1:0] read_data,
    output wire [`CHANNELS-1:0]            read_data_oe,
    output wire [`CHANNELS-1:0]            full_flag_n,
    output wire [`CHANNELS-1:0]            empty_flag_n,
    output wire [`CHANNELS-1:0]            input_room_flag_n,
    output wire [`CHANNELS-1:0]            output_ready_flag_n,
    output wire [`CHANNELS-1:0]            almost_full_flag_n,
    output wire [`CHANNELS-1:0]            almost_empty_flag_n,
    input  wire                            serial_clk,
    input  wire                            serial_write_n,
    input  wire                            serial_read_n,
    input  wire                            serial_in,
    output wire                            serial_out
);
    reg                    started_reg;
    reg                    fall_through_mode_reg;
    reg                    dual_reg;
    reg                    x20_reg;
    reg [1:0]              size_reg;
    reg [`CHAIN_BITS-1:0]  chain_reg;
    reg [`CHAIN_BITS-1:0]  chain_next;
    reg [`CHAIN_BITS-1:0]  scan_reg;
    reg                    scan_active_reg;
    reg                    serial_out_reg;
    reg                    serial_clk_d_reg;
    reg [4:0]              ofs_width;
    reg [7:0]              chain_len;
    reg [`COUNT_BITS-1:0]  depth;
    reg [16:0]             default_value;
    wire                   x20_dual;
    wire                   serial_edge;
    wire [1:0]             size_clip;
    integer                i;

    function [16:0] chain_field;
        input [`CHAIN_BITS-1:0] chain;
        input [3:0]             slot;
        input [4:0]             width;
        reg   [7:0]             shift;
        reg   [`CHAIN_BITS-1:0] moved;
        begin
            shift       = {4'h0, slot} * {3'h0, width};
            moved       = chain >> shift;
            chain_field = moved[16:0] & ~(17'h1_FFFF << width); // RULE21
        end
    endfunction

    assign x20_dual    = dual_reg & x20_reg;
    assign serial_edge = serial_clk & ~serial_clk_d_reg;
    assign serial_out  = serial_out_reg;
    assign size_clip   = (device_size > `SIZE_LARGEST) ? `SIZE_LARGEST : device_size;

    // configuration-derived widths and depth
    always @* begin
        ofs_width = (x20_dual ? `X20_OFS_WIDTH : `BASE_OFS_WIDTH) + {3'h0, size_reg};
        chain_len = dual_reg ? {1'b0, ofs_width, 2'h0} : {ofs_width, 3'h0}; // RULE22
        depth     = (`BASE_DEPTH << size_reg) >> x20_dual; // RULE6 RULE17
        case (default_offset_select)
            2'h0:    default_value = `DEFAULT_OFS_0;
            2'h1:    default_value = `DEFAULT_OFS_1;
            2'h2:    default_value = `DEFAULT_OFS_2;
            default: default_value = `DEFAULT_OFS_3;
        endcase
    end

    // next chain value: default fill at start, serial shift-in afterwards
    always @* begin
        chain_next = chain_reg;
        if (!started_reg) begin
            chain_next = {`CHAIN_BITS{1'b0}};
            for (i = 0; i < 8; i = i + 1) begin
                if (i < (dual_mode ? 4 : 8)) begin
                    chain_next = chain_next |
                        ({119'h0, default_value} << (i * ((dual_mode & port_width_select) ?
                        `X20_OFS_WIDTH + {3'h0, size_clip} :
                        `BASE_OFS_WIDTH + {3'h0, size_clip}))); // RULE25
                end
            end
        end else if (serial_edge & ~serial_write_n & serial_read_n) begin
            // first bit shifted in ends at bit 0 after a full load
            chain_next = (chain_reg >> 1) |
                ({135'h0, serial_in} << (chain_len - 8'h01)); // RULE20 RULE21
        end
    end

    // mode and size caught on the first edge after reset release
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            started_reg      <= 1'b0;
            fall_through_mode_reg         <= 1'b0;
            dual_reg         <= 1'b0;
            x20_reg          <= 1'b0;
            size_reg         <= 2'h0;
            chain_reg        <= {`CHAIN_BITS{1'b0}};
            scan_reg         <= {`CHAIN_BITS{1'b0}};
            scan_active_reg  <= 1'b0;
            serial_out_reg   <= 1'b0;
            serial_clk_d_reg <= 1'b0;
        end else begin
            serial_clk_d_reg <= serial_clk;
            chain_reg        <= chain_next;
            if (!started_reg) begin
                started_reg <= 1'b1;
                fall_through_mode_reg    <= fall_through_mode; // RULE23
                dual_reg    <= dual_mode;
                x20_reg     <= port_width_select;
                size_reg    <= size_clip;
            end
            // read copies the chain once, then shifts zeros in behind it
            if (serial_read_n) begin
                scan_active_reg <= 1'b0;
            end else if (!scan_active_reg) begin
                scan_active_reg <= 1'b1;
                scan_reg        <= chain_reg;
            end else if (serial_edge) begin
                serial_out_reg <= scan_reg[0];
                scan_reg       <= scan_reg >> 1;
            end
        end
    end

    genvar c;
    generate
        for (c = 0; c < `CHANNELS; c = c + 1) begin : chan
            reg  [`COUNT_BITS-1:0] count_reg;
            reg  [`EMPTY_STAGES-1:0] empty_pipe_reg;
            reg  [`FULL_STAGES-1:0]  full_pipe_reg;
            reg  [`ROOM_STAGES-1:0]  room_pipe_reg;
            reg  [`READY_STAGES-1:0] ready_pipe_reg;
            reg                    almost_full_reg;
            reg                    almost_empty_reg;
            reg                    presented_reg;
            reg                    oe_reg;
            reg  [`WORD_BITS-1:0]  data_reg;
            wire [3:0]             pair;
            wire [16:0]            ae_ofs;
            wire [16:0]            af_ofs;
            wire [`COUNT_BITS-1:0] full_level;
            wire [`COUNT_BITS-1:0] ae_level;
            wire [`COUNT_BITS-1:0] af_level;
            wire                   has_words;
            wire                   is_full;
            wire                   stage_ready;
            wire                   write_take;
            wire                   read_std;
            wire                   read_ft;
            wire                   read_take;
            wire                   fetch_ft;
            wire                   fetch;

            localparam [3:0] QUAD_PAIR = 3 - c;
            // dual chain: fifo 2 first pair, fifo 0 second
            assign pair   = dual_reg ? ((c == 2) ? 4'h0 : 4'h1) : QUAD_PAIR; // RULE20 RULE22
            assign ae_ofs = chain_field(chain_reg, {pair[2:0], 1'b0}, ofs_width); // RULE27
            assign af_ofs = chain_field(chain_reg, {pair[2:0], 1'b1}, ofs_width);

            // fall-through counts the word at the outputs, one more level
            assign full_level = depth + {17'h0, fall_through_mode_reg}; // RULE5 RULE16
            assign ae_level   = {1'b0, ae_ofs} + 18'h0_0001 + {17'h0, fall_through_mode_reg}; // RULE3 RULE14
            assign af_level   = full_level - {1'b0, af_ofs}; // RULE4 RULE15
            assign has_words  = (count_reg != {`COUNT_BITS{1'b0}});
            assign is_full    = (count_reg >= full_level);

            // a write needs both lows, room, and a free staging slot
            assign write_take = started_reg & ~write_enable_n[c] & ~write_select_n[c] &
                                ~is_full & stage_ready; // RULE1 RULE5 RULE16
            // empty fifo ignores read enable
            assign read_std  = ~fall_through_mode_reg & ~read_enable_n[c] & ~read_select_n[c] &
                               has_words; // RULE9 RULE10
            assign read_ft   = fall_through_mode_reg & presented_reg & ~read_enable_n[c] &
                               ~read_select_n[c]; // RULE18 RULE10
            assign read_take = read_std | read_ft;
            // first word fetched without read enable, next on each read
            assign fetch_ft  = fall_through_mode_reg & ((~presented_reg & ready_pipe_reg[1] & has_words) |
                               (read_ft & (count_reg > 18'h0_0001))); // RULE24
            assign fetch     = read_std | fetch_ft;

            stage_fifo #(
                .WIDTH    (`WORD_BITS),
                .DEPTH    (`STAGE_DEPTH),
                .PTR_BITS (`STAGE_PTR_BITS)
            ) u_stage (
                .sys_clk   (sys_clk),
                .arst_n    (arst_n),
                .in_valid  (write_take),
                .in_ready  (stage_ready),
                .in_data   (write_data[c*`WORD_BITS +: `WORD_BITS]),
                .out_valid (store_valid[c]),
                .out_ready (store_ready[c]),
                .out_data  (store_data[c*`WORD_BITS +: `WORD_BITS])
            );

            always @(posedge sys_clk or negedge arst_n) begin
                if (!arst_n) begin
                    count_reg        <= {`COUNT_BITS{1'b0}};
                    empty_pipe_reg   <= {`EMPTY_STAGES{1'b0}};
                    full_pipe_reg    <= {`FULL_STAGES{1'b1}};
                    room_pipe_reg    <= {`ROOM_STAGES{1'b1}};
                    ready_pipe_reg   <= {`READY_STAGES{1'b0}};
                    almost_full_reg  <= 1'b1;
                    almost_empty_reg <= 1'b0;
                    presented_reg    <= 1'b0;
                    oe_reg           <= 1'b0;
                    data_reg         <= {`WORD_BITS{1'b0}};
                end else begin
                    // flags follow the count the same way at single or double rate
                    if (write_take & ~read_take) begin
                        count_reg <= count_reg + 18'h0_0001; // RULE2 RULE13 RULE12
                    end else if (read_take & ~write_take) begin
                        count_reg <= count_reg - 18'h0_0001; // RULE7
                    end
                    empty_pipe_reg <= {empty_pipe_reg[0], has_words}; // RULE11 RULE2 RULE9
                    full_pipe_reg  <= {full_pipe_reg[0], ~is_full}; // RULE11 RULE7
                    room_pipe_reg  <= {room_pipe_reg[0], ~is_full}; // RULE19 RULE16
                    ready_pipe_reg <= {ready_pipe_reg[1:0], has_words}; // RULE19 RULE13
                    almost_full_reg  <= ~(count_reg >= af_level); // RULE4 RULE7 RULE26
                    almost_empty_reg <= (count_reg >= ae_level); // RULE3 RULE8 RULE26
                    oe_reg <= ~read_select_n[c]; // RULE10
                    if (fetch) begin
                        data_reg <= fetch_data[c*`WORD_BITS +: `WORD_BITS];
                    end
                    if (fetch_ft) begin
                        presented_reg <= 1'b1;
                    end else if (read_ft) begin
                        presented_reg <= 1'b0;
                    end
                end
            end

            assign fetch_req[c]           = fetch;
            assign read_data[c*`WORD_BITS +: `WORD_BITS] = data_reg;
            assign read_data_oe[c]        = oe_reg;
            assign empty_flag_n[c]        = fall_through_mode_reg | empty_pipe_reg[`EMPTY_STAGES-1];
            assign full_flag_n[c]         = fall_through_mode_reg | full_pipe_reg[`FULL_STAGES-1];
            assign input_room_flag_n[c]   = ~fall_through_mode_reg | room_pipe_reg[`ROOM_STAGES-1];
            assign output_ready_flag_n[c] = ~fall_through_mode_reg | ~ready_pipe_reg[`READY_STAGES-1];
            assign almost_full_flag_n[c]  = almost_full_reg;
            assign almost_empty_flag_n[c] = almost_empty_reg;
        end
    endgenerate
endmodule // fifo_status_flag_logic

// [test/storage_model.sv]
// word storage behind the store and fetch ports of the flag block
// assumes sys_clk shared with the block; stall holds off the staging drain
`timescale 1ns/100ps
module storage_model (
    input  wire        sys_clk,
    input  wire        arst_n,
    input  wire [3:0]  store_valid,
    output wire [3:0]  store_ready,
    input  wire [39:0] store_data,
    input  wire [3:0]  fetch_req,
    output reg  [39:0] fetch_data = 40'h00_0000_0000,
    input  wire [3:0]  stall
);
    logic [9:0] q[4][$];
    logic       tick_reg = 1'b0;
    assign store_ready = ~stall;
    always @(posedge sys_clk) begin
        for (int c = 0; c < 4; c++) begin
            if (!arst_n)
                q[c].delete();
            if (arst_n && fetch_req[c] && q[c].size() > 0)
                void'(q[c].pop_front());
            if (arst_n && store_valid[c] && store_ready[c])
                q[c].push_back(store_data[c*10+:10]);
            // nothing stored: junk that changes every cycle
            fetch_data[c*10+:10] <= (q[c].size() > 0) ? q[c][0] : {5{tick_reg, !tick_reg}};
        end
        tick_reg <= !tick_reg;
    end
endmodule // storage_model

// [test/fifo_status_flag_logic_asserts.sv]
// channel 0 flag timing and read-side checks for the flag block
// assumes mode pins steady from reset release, bound to the top module
`timescale 1ns/100ps
module fifo_flag_asserts (
    input wire       sys_clk,
    input wire       arst_n,
    input wire       fall_through_mode,
    input wire [3:0] write_enable_n,
    input wire [3:0] write_select_n,
    input wire [3:0] read_enable_n,
    input wire [3:0] read_select_n,
    input wire [3:0] store_valid,
    input wire [3:0] fetch_req,
    input wire [3:0] read_data_oe,
    input wire [3:0] full_flag_n,
    input wire [3:0] empty_flag_n,
    input wire [3:0] input_room_flag_n,
    input wire [3:0] output_ready_flag_n
);
    reg  started_reg;
    reg  ft_reg;
    wire wr0 = !write_enable_n[0] && !write_select_n[0];
    wire rd0 = !read_enable_n[0] && !read_select_n[0];
    always @(posedge sys_clk or negedge arst_n) begin
        if (!arst_n) begin
            started_reg <= 1'b0;
            ft_reg      <= 1'b0;
        end else if (!started_reg) begin
            started_reg <= 1'b1;
            ft_reg      <= fall_through_mode;
        end
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!arst_n || !started_reg);
    sequence seq_std_empty;
        (!ft_reg && !empty_flag_n[0] && !wr0 && !store_valid[0])[*3];
    endsequence
    sequence seq_ft_empty;
        (ft_reg && output_ready_flag_n[0] && !wr0 && !store_valid[0])[*4];
    endsequence
    sequence seq_std_full;
        (!ft_reg && !full_flag_n[0] && !fetch_req[0])[*3];
    endsequence
    sequence seq_ft_full;
        (ft_reg && !input_room_flag_n[0] && !rd0)[*3];
    endsequence
    AST_OE_SELECT: assert property (read_data_oe[0] == !$past(read_select_n[0]))
        else $error("oe does not follow read select");
    AST_STD_REQ: assert property (!ft_reg && fetch_req[0] |-> rd0)
        else $error("fetch without read enable");
    AST_STD_FIRST: assert property (seq_std_empty ##1 wr0 |-> ##3 empty_flag_n[0])
        else $error("empty flag late");
    AST_STD_NO_READ: assert property (seq_std_empty |-> !fetch_req[0])
        else $error("read taken while empty");
    AST_FT_FIRST: assert property (seq_ft_empty ##1 wr0 |-> ##3 fetch_req[0] ##1 !output_ready_flag_n[0])
        else $error("first word late");
    AST_FT_NO_READ: assert property (seq_ft_empty |-> !fetch_req[0])
        else $error("fetch while nothing stored");
    AST_STD_FULL_REL: assert property (seq_std_full ##1 fetch_req[0] |-> ##3 full_flag_n[0])
        else $error("full flag stuck");
    AST_FT_ROOM_REL: assert property (seq_ft_full ##1 rd0 |-> ##3 input_room_flag_n[0])
        else $error("room flag stuck");
endmodule // fifo_flag_asserts
bind fifo_status_flag_logic fifo_flag_asserts chk_u (.sys_clk, .arst_n, .fall_through_mode,
    .write_enable_n, .write_select_n, .read_enable_n, .read_select_n, .store_valid, .fetch_req,
    .read_data_oe, .full_flag_n, .empty_flag_n, .input_room_flag_n, .output_ready_flag_n);

// [test/fifo_status_flag_logic_tb.sv]
// self-checking bench for the four-channel fifo flag block
// assumes storage_model on the far side and the bound checker
`timescale 1ns/100ps
module fifo_status_flag_logic_tb;
    reg         sys_clk = 1'b0;
    reg         arst_n = 1'b0;
    reg         ft = 1'b0;
    reg         dual = 1'b0;
    reg         x20 = 1'b0;
    reg  [3:0]  wen_n = 4'hF;
    reg  [3:0]  wsel_n = 4'hF;
    reg  [39:0] wdata = 40'h00_0000_0000;
    reg  [3:0]  ren_n = 4'hF;
    reg  [3:0]  rsel_n = 4'hF;
    reg  [3:0]  stall = 4'h0;
    reg         sclk = 1'b0;
    reg         sread_n = 1'b1;
    wire [3:0]  sv, sr, freq, oe, full_n, empty_n, room_n, rdy_n, afull_n, aempty_n;
    wire [39:0] sd, fd, rd;
    wire        sout;
    integer     failures = 0;
    integer     checks_done = 0;
    always #10 sys_clk = !sys_clk;
    fifo_status_flag_logic dut_u (.sys_clk(sys_clk), .arst_n(arst_n), .fall_through_mode(ft),
        .dual_mode(dual), .port_width_select(x20), .device_size(2'h0),
        .default_offset_select(2'h0), .write_enable_n(wen_n), .write_select_n(wsel_n),
        .write_data(wdata), .store_valid(sv), .store_ready(sr), .store_data(sd),
        .read_enable_n(ren_n), .read_select_n(rsel_n), .fetch_req(freq), .fetch_data(fd),
        .read_data(rd), .read_data_oe(oe), .full_flag_n(full_n), .empty_flag_n(empty_n),
        .input_room_flag_n(room_n), .output_ready_flag_n(rdy_n), .almost_full_flag_n(afull_n),
        .almost_empty_flag_n(aempty_n), .serial_clk(sclk), .serial_write_n(1'b1),
        .serial_read_n(sread_n), .serial_in(1'b0), .serial_out(sout));
    storage_model storage_u (.sys_clk(sys_clk), .arst_n(arst_n), .store_valid(sv),
        .store_ready(sr), .store_data(sd), .fetch_req(freq), .fetch_data(fd), .stall(stall));
    task wrap_up;
        if (failures == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task check_bit(input string name, input logic exp, input logic got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %b seen %b", name, exp, got);
        end
    endtask
    task check_word(input string name, input logic [15:0] exp, input logic [15:0] got);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    task settle(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task reset_dut(input logic f, input logic d, input logic w);
        @(posedge sys_clk);
        arst_n <= 1'b0;
        ft <= f;
        dual <= d;
        x20 <= w;
        repeat (5) @(posedge sys_clk);
        arst_n <= 1'b1;
        settle(2);
    endtask
    task writes(input int ch, input int n, input int base);
        @(posedge sys_clk);
        for (int i = 0; i < n; i++) begin
            wen_n[ch] <= 1'b0;
            wsel_n[ch] <= 1'b0;
            wdata[ch*10+:10] <= 10'(base + i);
            @(posedge sys_clk);
        end
        wen_n[ch] <= 1'b1;
        wsel_n[ch] <= 1'b1;
    endtask
    task read_one(input int ch, input logic [9:0] exp);
        @(posedge sys_clk);
        ren_n[ch] <= 1'b0;
        rsel_n[ch] <= 1'b0;
        @(posedge sys_clk);
        ren_n[ch] <= 1'b1;
        #1;
        check_word("read data", {6'h00, exp}, {6'h00, rd[ch*10+:10]});
    endtask
    task serial_defaults;
        @(posedge sys_clk);
        sread_n <= 1'b0;
        for (int i = 0; i < 15; i++) begin
            repeat (2) @(posedge sys_clk);
            sclk <= 1'b1;
            repeat (2) @(posedge sys_clk);
            sclk <= 1'b0;
            settle(2);
            check_bit("serial out", i < 3, sout);
        end
        @(posedge sys_clk);
        sread_n <= 1'b1;
    endtask
    task std_basic;
        reset_dut(1'b0, 1'b0, 1'b0);
        check_bit("empty at reset", 1'b0, empty_n[0]);
        check_bit("full at reset", 1'b1, full_n[0]);
        serial_defaults;
        writes(0, 7, 0);
        settle(4);
        check_bit("empty flag", 1'b1, empty_n[0]);
        check_bit("almost empty at n", 1'b0, aempty_n[0]);
        writes(0, 1, 7);
        settle(3);
        check_bit("almost empty at n+1", 1'b1, aempty_n[0]);
        read_one(0, 10'h000);
        settle(3);
        check_bit("almost empty back", 1'b0, aempty_n[0]);
        for (int i = 1; i < 8; i++)
            read_one(0, 10'(i));
        settle(4);
        check_bit("empty after last", 1'b0, empty_n[0]);
        read_one(0, 10'h007);
        check_bit("oe selected", 1'b1, oe[0]);
        @(posedge sys_clk);
        rsel_n[0] <= 1'b1;
        stall[1] <= 1'b1;
        writes(1, 20, 0);
        settle(2);
        check_bit("oe released", 1'b0, oe[0]);
        @(posedge sys_clk);
        stall[1] <= 1'b0;
        settle(30);
        check_word("stored ch1", 16'h0011, 16'(storage_u.q[1].size()));
    endtask
    task std_full;
        reset_dut(1'b0, 1'b1, 1'b1);
        writes(0, 16376, 0);
        settle(3);
        check_bit("almost full below", 1'b1, afull_n[0]);
        writes(0, 1, 0);
        settle(3);
        check_bit("almost full at d-m", 1'b0, afull_n[0]);
        writes(0, 6, 0);
        settle(4);
        check_bit("full below depth", 1'b1, full_n[0]);
        writes(0, 2, 0);
        settle(4);
        check_bit("full at depth", 1'b0, full_n[0]);
        check_word("stored ch0", 16'h4000, 16'(storage_u.q[0].size()));
        read_one(0, 10'h000);
        settle(3);
        check_bit("full released", 1'b1, full_n[0]);
        check_bit("almost full held", 1'b0, afull_n[0]);
    endtask
    task ft_fill;
        reset_dut(1'b1, 1'b1, 1'b1);
        check_bit("ready at reset", 1'b1, rdy_n[0]);
        @(posedge sys_clk);
        rsel_n[0] <= 1'b0;
        settle(4);
        writes(0, 1, 0);
        settle(4);
        check_bit("ready after write", 1'b0, rdy_n[0]);
        check_word("fell through", 16'h0000, {6'h00, rd[9:0]});
        writes(0, 7, 1);
        settle(3);
        check_bit("almost empty n+1", 1'b0, aempty_n[0]);
        writes(0, 1, 8);
        settle(3);
        check_bit("almost empty n+2", 1'b1, aempty_n[0]);
        writes(0, 16368, 9);
        settle(3);
        check_bit("almost full below", 1'b1, afull_n[0]);
        writes(0, 1, 0);
        settle(3);
        check_bit("almost full at d+1-m", 1'b0, afull_n[0]);
        writes(0, 8, 0);
        settle(4);
        check_bit("room at d+1", 1'b0, room_n[0]);
        check_word("stored ch0", 16'h4000, 16'(storage_u.q[0].size()));
        read_one(0, 10'h001);
        settle(3);
        check_bit("room released", 1'b1, room_n[0]);
    endtask
    initial begin
        std_basic;
        std_full;
        ft_fill;
        wrap_up;
    end
    initial begin
        repeat (80000) @(posedge sys_clk);
        failures++;
        wrap_up;
    end
endmodule // fifo_status_flag_logic_tb
